// ### inc/dsau_pkg.sv
// Constants and types of the data space access unit
package dsau_pkg;
    // ------------------------------------------------------------
    // Data space map
    // ------------------------------------------------------------
    localparam int AW = 16;
    localparam int RGN_N = 4;
    localparam int RGN_REG = 0;
    localparam int RGN_IO = 1;
    localparam int RGN_EXT = 2;
    localparam int RGN_SRAM = 3;
    localparam logic [15:0] RGN_BASE [0:3] = '{16'h0000, 16'h0020, 16'h0060, 16'h0100};
    localparam logic [15:0] RGN_TOP [0:2] = '{16'h001f, 16'h005f, 16'h00ff};
    // SRAM top per size variant, picked by the config register
    localparam logic [15:0] SRAM_TOP [0:3] = '{16'h02ff, 16'h04ff, 16'h04ff, 16'h08ff};
    localparam logic [15:0] IO_OPC_OFS = 16'h0020;
    localparam logic [15:0] PTR_STEP = 16'h0001;

    // ------------------------------------------------------------
    // EEPROM registers in the standard I/O space
    // ------------------------------------------------------------
    localparam logic [15:0] EE_CTRL_ADR = 16'h003f;
    localparam logic [15:0] EE_DATA_ADR = 16'h0040;
    localparam logic [15:0] EE_ADRL_ADR = 16'h0041;
    localparam logic [15:0] EE_ADRH_ADR = 16'h0042;
    localparam int CB_RD = 0;
    localparam int CB_STB = 1;
    localparam int CB_UNL = 2;
    localparam int CB_IEN = 3;
    localparam int CB_PM = 4;
    localparam int EE_AW = 10;
    localparam int EE_DEPTH = 1024;
    localparam logic [7:0] EE_ERASED = 8'hff;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam real CLK_HZ = 40.0e6;
    localparam real ATOMIC_MS = 3.4;
    localparam real SPLIT_MS = 1.8;
    localparam int ATOMIC_CYC = int'(ATOMIC_MS * 1.0e-3 * CLK_HZ);
    localparam int SPLIT_CYC = int'(SPLIT_MS * 1.0e-3 * CLK_HZ);
    localparam int CNT_W = 18;
    localparam logic [2:0] UNLOCK_CYC = 3'h4;
    localparam logic [2:0] RD_STALL = 3'h4;
    localparam logic [2:0] WR_STALL = 3'h2;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PM_ATOMIC = 2'h0, PM_ERASE = 2'h1, PM_WRITE = 2'h2, PM_RSVD = 2'h3} dsau_pm_t;
    typedef enum logic [2:0] {
        AM_DIRECT = 3'h0, AM_INDIRECT = 3'h1, AM_DISP = 3'h2, AM_PREDEC = 3'h3, AM_POSTINC = 3'h4
    } dsau_am_t;
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;

    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam int PAW = 12;
    localparam logic [11:0] APB_CFG = 12'h000;
    localparam logic [11:0] APB_STAT = 12'h004;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam int ST_BUSY = 0;
    localparam int ST_STALL = 1;
    localparam int ST_UNL = 2;
    localparam int ST_SEL = 4;
endpackage : dsau_pkg

// ### hw/dsau_decode.sv
// Region decoder of the data space address
`timescale 1ns/100ps
module dsau_decode (
    input wire logic [15:0] addr,
    input wire logic [15:0] sram_top,
    output logic [3:0] sel
);
    // ------------------------------------------------------------
    // Range compare
    // ------------------------------------------------------------
    function automatic logic in_rng(input logic [15:0] a, lo, hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    // Regions are disjoint, so at most one select is high
    for (genvar i = 0; i < dsau_pkg::RGN_N; i++)
    begin : g_rgn
        if (i == dsau_pkg::RGN_SRAM)
        begin : g_sram
            assign sel[i] = in_rng(addr, dsau_pkg::RGN_BASE[i], sram_top); // RL4
        end
        else
        begin : g_fix
            assign sel[i] = in_rng(addr, dsau_pkg::RGN_BASE[i], dsau_pkg::RGN_TOP[i]); // RL1 RL2 RL3
        end
    end
endmodule : dsau_decode

// ### hw/dsau_eeprom.sv
// EEPROM array with self-timed programming
`timescale 1ns/100ps
module dsau_eeprom #(
    parameter int ATOMIC_CYC = dsau_pkg::ATOMIC_CYC,
    parameter int SPLIT_CYC = dsau_pkg::SPLIT_CYC
) (
    input wire logic clk,
    input wire logic por_rst,
    input wire logic start,
    input wire dsau_pkg::dsau_pm_t mode,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [9:0] rd_addr,
    output logic [7:0] rd_data,
    output logic busy
);
    logic [7:0] mem [0:dsau_pkg::EE_DEPTH-1];
    logic [dsau_pkg::CNT_W-1:0] cnt_ff;
    logic [9:0] op_addr_ff;
    logic [7:0] op_data_ff;
    dsau_pkg::dsau_pm_t op_mode_ff;
    logic busy_ff;
    logic last;

    assign last = (cnt_ff == dsau_pkg::CNT_W'(1));

    // Power-on reset only: a system reset never cuts a write short
    always_ff @(posedge clk or posedge por_rst)
    begin
        if (por_rst)
        begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            op_addr_ff <= '0;
            op_data_ff <= '0;
            op_mode_ff <= dsau_pkg::PM_ATOMIC;
        end
        else if (start && !busy_ff && mode != dsau_pkg::PM_RSVD)
        begin
            cnt_ff <= (mode == dsau_pkg::PM_ATOMIC) ? dsau_pkg::CNT_W'(ATOMIC_CYC) : dsau_pkg::CNT_W'(SPLIT_CYC); // RL19
            busy_ff <= 1'b1; // RL15
            op_addr_ff <= addr;
            op_data_ff <= wdata;
            op_mode_ff <= mode;
        end
        else if (busy_ff)
        begin
            cnt_ff <= cnt_ff - dsau_pkg::CNT_W'(1);
            busy_ff <= !last; // RL17
        end
    end

    // Cell update when programming ends
    always_ff @(posedge clk)
    begin
        if (busy_ff && last)
        begin
            unique case (op_mode_ff)
                dsau_pkg::PM_ERASE: mem[op_addr_ff] <= dsau_pkg::EE_ERASED; // RL19
                dsau_pkg::PM_WRITE: mem[op_addr_ff] <= mem[op_addr_ff] & op_data_ff; // RL19
                default: mem[op_addr_ff] <= op_data_ff; // RL13
            endcase
        end
    end

    assign rd_data = mem[rd_addr];
    assign busy = busy_ff;
endmodule : dsau_eeprom

// ### hw/dsau_top.sv
// Data space access unit top: address forming, decode, EEPROM control
// Functional notes
// (RL1) Addresses 0x0000-0x001F select the working register file.
// (RL2) Next 64 addresses, 0x0020-0x005F, select standard I/O.
// (RL3) Next 160 addresses, 0x0060-0x00FF, select extended I/O.
// (RL4) 0x0100 up to the variant top selects SRAM.
// (RL5) Short I/O opcodes reach only the first 64 I/O locations.
// (RL6) Displacement adds an unsigned 0..63 offset to Y or Z; the code also accepts X.
// (RL7) Pre-decrement and post-increment step the pointer by one.
// (RL8) Direct mode reaches the whole data space.
// (RL9) All regions reachable in all five modes.
// (RL10) Two-cycle access: address compute, then read or write.
// (RL11) An EEPROM read stalls the CPU for four cycles.
// (RL12) An EEPROM write stalls the CPU for two cycles.
// (RL13) EEPROM is a separate byte-addressed space.
// (RL14) EEPROM address, data and control registers sit in I/O space.
// (RL15) Programming is self-timed; the write strobe shows busy.
// (RL16) A write starts only after the unlock sequence.
// (RL17) A reset during programming lets the write finish.
// (RL18) Unlock opens a four-cycle window, then clears itself.
// (RL19) Mode field: atomic, erase only, write only, reserved.
// (RL20) Mode writes ignored while strobe set; reset clears when idle.
// (RL21) Ready interrupt is high while enabled and strobe clear.
// (RL22) Exactly one region select per access, none above SRAM top.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
module dsau_top #(
    parameter int ATOMIC_CYC = dsau_pkg::ATOMIC_CYC,
    parameter int SPLIT_CYC = dsau_pkg::SPLIT_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic acc_req,
    input wire dsau_pkg::dsau_am_t acc_mode,
    input wire logic acc_write,
    input wire logic acc_io_op,
    input wire logic [5:0] io_addr,
    input wire logic [15:0] dir_addr,
    input wire logic [1:0] ptr_sel,
    input wire logic [15:0] ptr_x,
    input wire logic [15:0] ptr_y,
    input wire logic [15:0] ptr_z,
    input wire logic [5:0] disp,
    input wire logic [7:0] acc_wdata,
    output logic [15:0] mem_addr,
    output logic [3:0] mem_sel,
    output logic mem_we,
    output logic mem_re,
    output logic [7:0] mem_wdata,
    output logic acc_done,
    output logic [7:0] io_rdata,
    output logic io_rdata_vld,
    output logic ptr_wb,
    output logic [1:0] ptr_wb_sel,
    output logic [15:0] ptr_wb_val,
    output logic cpu_stall,
    output logic ee_ready_irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [15:0] ptr_v;
    logic [15:0] eff_addr;
    logic [15:0] wb_val;
    logic wb_c;
    logic [3:0] sel_c;
    logic ctrl_wr;
    logic rd_trig;
    logic wr_trig;
    logic ee_busy;
    logic [7:0] ee_rd_data;
    logic [7:0] ee_rbyte;
    logic ee_hit;
    logic [1:0] cfg_ff;
    logic unlock_ff;
    logic [2:0] unl_cnt_ff;
    logic strobe_ff;
    logic irq_en_ff;
    dsau_pkg::dsau_pm_t mode_ff;
    logic [9:0] ee_addr_ff;
    logic [7:0] ee_data_ff;
    logic [2:0] stall_cnt_ff;
    logic [15:0] mem_addr_ff;
    logic [3:0] mem_sel_ff;
    logic mem_we_ff;
    logic mem_re_ff;
    logic [7:0] mem_wdata_ff;
    logic acc_done_ff;
    logic [7:0] io_rdata_ff;
    logic io_rdata_vld_ff;
    logic ptr_wb_ff;
    logic [1:0] ptr_wb_sel_ff;
    logic [15:0] ptr_wb_val_ff;
    logic cpu_stall_ff;
    logic ee_ready_irq_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // ------------------------------------------------------------
    // Address forming
    // ------------------------------------------------------------
    // Pointer pick, address and write-back
    always_comb
    begin
        unique case (ptr_sel)
            dsau_pkg::PTR_Y: ptr_v = ptr_y;
            dsau_pkg::PTR_Z: ptr_v = ptr_z;
            default: ptr_v = ptr_x;
        endcase
        wb_c = 1'b0;
        wb_val = ptr_v;
        eff_addr = dir_addr;
        if (acc_io_op)
        begin
            eff_addr = 16'(io_addr) + dsau_pkg::IO_OPC_OFS; // RL5
        end
        else
        begin
            unique case (acc_mode)
                dsau_pkg::AM_DIRECT: eff_addr = dir_addr; // RL8
                dsau_pkg::AM_INDIRECT: eff_addr = ptr_v; // RL9
                dsau_pkg::AM_DISP: eff_addr = ptr_v + 16'(disp); // RL6
                dsau_pkg::AM_PREDEC:
                begin
                    wb_val = ptr_v - dsau_pkg::PTR_STEP; // RL7
                    eff_addr = wb_val;
                    wb_c = 1'b1;
                end
                dsau_pkg::AM_POSTINC:
                begin
                    wb_val = ptr_v + dsau_pkg::PTR_STEP; // RL7
                    wb_c = 1'b1;
                    eff_addr = ptr_v;
                end
                default: eff_addr = dir_addr;
            endcase
        end
    end

    dsau_decode u_decode (
        .addr(eff_addr),
        .sram_top(dsau_pkg::SRAM_TOP[cfg_ff]),
        .sel(sel_c)
    );

    // ------------------------------------------------------------
    // EEPROM register decode
    // ------------------------------------------------------------
    assign ctrl_wr = acc_req && acc_write && (eff_addr == dsau_pkg::EE_CTRL_ADR); // RL14
    assign wr_trig = ctrl_wr && acc_wdata[dsau_pkg::CB_STB] && unlock_ff && !strobe_ff; // RL16
    assign rd_trig = ctrl_wr && acc_wdata[dsau_pkg::CB_RD] && !strobe_ff;

    // Read-back byte of the EEPROM registers
    always_comb
    begin
        ee_hit = 1'b1;
        unique case (eff_addr)
            dsau_pkg::EE_CTRL_ADR: ee_rbyte = {2'h0, mode_ff, irq_en_ff, unlock_ff, strobe_ff, 1'b0};
            dsau_pkg::EE_DATA_ADR: ee_rbyte = ee_data_ff;
            dsau_pkg::EE_ADRL_ADR: ee_rbyte = ee_addr_ff[7:0];
            dsau_pkg::EE_ADRH_ADR: ee_rbyte = {6'h00, ee_addr_ff[9:8]};
            default:
            begin
                ee_hit = 1'b0;
                ee_rbyte = 8'h00;
            end
        endcase
    end

    dsau_eeprom #(
        .ATOMIC_CYC(ATOMIC_CYC),
        .SPLIT_CYC(SPLIT_CYC)
    ) u_eeprom (
        .clk(clk),
        .por_rst(por_rst),
        .start(wr_trig),
        .mode(mode_ff),
        .addr(ee_addr_ff),
        .wdata(ee_data_ff),
        .rd_addr(ee_addr_ff),
        .rd_data(ee_rd_data),
        .busy(ee_busy)
    );

    // ------------------------------------------------------------
    // Access sequencing
    // ------------------------------------------------------------
    // Request cycle computes, the next cycle accesses
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mem_addr_ff <= '0;
            mem_sel_ff <= '0;
            mem_we_ff <= 1'b0;
            mem_re_ff <= 1'b0;
            mem_wdata_ff <= '0;
            acc_done_ff <= 1'b0;
            io_rdata_ff <= '0;
            io_rdata_vld_ff <= 1'b0;
            ptr_wb_ff <= 1'b0;
            ptr_wb_sel_ff <= '0;
            ptr_wb_val_ff <= '0;
        end
        else
        begin
            mem_sel_ff <= acc_req ? sel_c : '0; // RL22
            mem_we_ff <= acc_req && acc_write; // RL10
            mem_re_ff <= acc_req && !acc_write;
            acc_done_ff <= acc_req; // RL10
            io_rdata_vld_ff <= acc_req && !acc_write && ee_hit;
            ptr_wb_ff <= acc_req && wb_c && !acc_io_op; // RL7
            if (acc_req)
            begin
                mem_addr_ff <= eff_addr;
                mem_wdata_ff <= acc_wdata;
                io_rdata_ff <= ee_rbyte;
                ptr_wb_sel_ff <= ptr_sel;
                ptr_wb_val_ff <= wb_val;
            end
        end
    end

    // ------------------------------------------------------------
    // EEPROM control
    // ------------------------------------------------------------
    // Unlock window, reloaded by each unlock write that leaves the strobe bit clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            unlock_ff <= 1'b0;
            unl_cnt_ff <= '0;
        end
        else if (ctrl_wr && acc_wdata[dsau_pkg::CB_UNL] && !acc_wdata[dsau_pkg::CB_STB])
        begin
            unlock_ff <= 1'b1; // RL18
            unl_cnt_ff <= dsau_pkg::UNLOCK_CYC - 3'h1;
        end
        else if (unl_cnt_ff != 3'h0)
        begin
            unl_cnt_ff <= unl_cnt_ff - 3'h1;
        end
        else
        begin
            unlock_ff <= 1'b0; // RL18
        end
    end

    // Strobe survives a system reset; mode survives it only while the EEPROM is busy
    always_ff @(posedge clk or posedge por_rst)
    begin
        if (por_rst)
        begin
            strobe_ff <= 1'b0;
            mode_ff <= dsau_pkg::PM_ATOMIC;
        end
        else
        begin
            strobe_ff <= wr_trig || (strobe_ff && ee_busy); // RL15 RL17
            if (sys_rst && !ee_busy)
            begin
                mode_ff <= dsau_pkg::PM_ATOMIC; // RL20
            end
            else if (ctrl_wr && !strobe_ff)
            begin
                mode_ff <= dsau_pkg::dsau_pm_t'(acc_wdata[dsau_pkg::CB_PM +: 2]); // RL20
            end
        end
    end

    // Address, data, enable and read transfer
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_en_ff <= 1'b0;
            ee_addr_ff <= '0;
            ee_data_ff <= '0;
        end
        else if (acc_req && acc_write)
        begin
            if (ctrl_wr)
            begin
                irq_en_ff <= acc_wdata[dsau_pkg::CB_IEN];
            end
            if (rd_trig)
            begin
                ee_data_ff <= ee_rd_data; // RL13
            end
            else if (eff_addr == dsau_pkg::EE_DATA_ADR)
            begin
                ee_data_ff <= acc_wdata;
            end
            if (eff_addr == dsau_pkg::EE_ADRL_ADR)
            begin
                ee_addr_ff[7:0] <= acc_wdata;
            end
            if (eff_addr == dsau_pkg::EE_ADRH_ADR)
            begin
                ee_addr_ff[9:8] <= acc_wdata[1:0];
            end
        end
    end

    // Stall counter and ready interrupt
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stall_cnt_ff <= '0;
            cpu_stall_ff <= 1'b0;
            ee_ready_irq_ff <= 1'b0;
        end
        else
        begin
            ee_ready_irq_ff <= irq_en_ff && !strobe_ff && !wr_trig; // RL21
            if (rd_trig)
            begin
                stall_cnt_ff <= dsau_pkg::RD_STALL - 3'h1; // RL11
                cpu_stall_ff <= 1'b1;
            end
            else if (wr_trig)
            begin
                stall_cnt_ff <= dsau_pkg::WR_STALL - 3'h1; // RL12
                cpu_stall_ff <= 1'b1;
            end
            else if (stall_cnt_ff != 3'h0)
            begin
                stall_cnt_ff <= stall_cnt_ff - 3'h1;
            end
            else
            begin
                cpu_stall_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // No wait states; unmapped offsets answer with an error
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
            cfg_ff <= dsau_pkg::CFG_RST;
        end
        else
        begin
            pready_ff <= psel && !penable;
            pslverr_ff <= psel && !penable && (paddr != dsau_pkg::APB_CFG) && (paddr != dsau_pkg::APB_STAT);
            if (psel && !penable && !pwrite)
            begin
                prdata_ff <= '0;
                if (paddr == dsau_pkg::APB_CFG)
                begin
                    prdata_ff[1:0] <= cfg_ff;
                end
                if (paddr == dsau_pkg::APB_STAT)
                begin
                    prdata_ff[dsau_pkg::ST_BUSY] <= ee_busy;
                    prdata_ff[dsau_pkg::ST_STALL] <= cpu_stall_ff;
                    prdata_ff[dsau_pkg::ST_UNL] <= unlock_ff;
                    prdata_ff[dsau_pkg::ST_SEL +: 4] <= mem_sel_ff;
                end
            end
            if (psel && penable && pready_ff && pwrite && paddr == dsau_pkg::APB_CFG)
            begin
                cfg_ff <= pwdata[1:0];
            end
        end
    end

    assign mem_addr = mem_addr_ff;
    assign mem_sel = mem_sel_ff;
    assign mem_we = mem_we_ff;
    assign mem_re = mem_re_ff;
    assign mem_wdata = mem_wdata_ff;
    assign acc_done = acc_done_ff;
    assign io_rdata = io_rdata_ff;
    assign io_rdata_vld = io_rdata_vld_ff;
    assign ptr_wb = ptr_wb_ff;
    assign ptr_wb_sel = ptr_wb_sel_ff;
    assign ptr_wb_val = ptr_wb_val_ff;
    assign cpu_stall = cpu_stall_ff;
    assign ee_ready_irq = ee_ready_irq_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || por_rst);

    sequence s_rd_stall;
        cpu_stall_ff [*4] ##1 !cpu_stall_ff;
    endsequence
    sequence s_wr_stall;
        cpu_stall_ff [*2] ##1 !cpu_stall_ff;
    endsequence

    reg_region_a: assert property (acc_done_ff && mem_addr_ff <= dsau_pkg::RGN_TOP[0] |-> mem_sel_ff == 4'h1) // RL1
        else $error("register file not selected");
    io_short_a: assert property (acc_req && acc_io_op |=> mem_sel_ff == 4'h2) // RL5
        else $error("short I/O left I/O space");
    one_sel_a: assert property (acc_done_ff |-> $onehot(mem_sel_ff) == (mem_addr_ff <= dsau_pkg::SRAM_TOP[cfg_ff])) // RL22
        else $error("region select count wrong");
    acc_two_a: assert property (acc_req && !acc_write |=> mem_re_ff && acc_done_ff ##1 (!mem_re_ff || $past(acc_req))) // RL10
        else $error("access not two cycles");
    post_inc_a: assert property (acc_req && !acc_io_op && acc_mode == dsau_pkg::AM_POSTINC
        |=> ptr_wb_ff && ptr_wb_val_ff == mem_addr_ff + dsau_pkg::PTR_STEP) // RL7
        else $error("post-increment wrong");
    rd_stall_a: assert property (rd_trig |=> s_rd_stall) // RL11
        else $error("read stall not four cycles");
    wr_stall_a: assert property (wr_trig |=> s_wr_stall) // RL12
        else $error("write stall not two cycles");
    unlock_win_a: assert property ($rose(unlock_ff) && !ctrl_wr |-> unlock_ff [*4]) // RL18
        else $error("unlock window too short");
    strobe_lock_a: assert property (!unlock_ff && ctrl_wr |=> !$rose(strobe_ff)) // RL16
        else $error("write started without unlock");
    mode_hold_a: assert property (strobe_ff && $past(strobe_ff) |-> $stable(mode_ff)) // RL20
        else $error("mode changed while strobe set");
    irq_busy_a: assert property ($rose(strobe_ff) |-> !ee_ready_irq_ff) // RL21
        else $error("ready irq during write");
endmodule : dsau_top

// ### test/dsau_cpu_model.sv
// CPU core model issuing data accesses
`timescale 1ns/100ps
module dsau_cpu_model (
    input wire logic clk,
    input wire logic cpu_stall,
    output logic acc_req = 1'b0,
    output dsau_pkg::dsau_am_t acc_mode = dsau_pkg::AM_DIRECT,
    output logic acc_write = 1'b0,
    output logic acc_io_op = 1'b0,
    output logic [15:0] dir_addr = 16'h0000,
    output logic [7:0] acc_wdata = 8'h00
);
    // One access; a stalled core holds off, released lines carry junk
    task automatic acc(input dsau_pkg::dsau_am_t m, input logic w, io, input logic [15:0] a,
        input logic [7:0] d);
        while (cpu_stall === 1'b1)
            @(posedge clk);
        acc_req <= 1'b1;
        acc_mode <= m;
        acc_write <= w;
        acc_io_op <= io;
        dir_addr <= a;
        acc_wdata <= d;
        @(posedge clk);
        acc_req <= 1'b0;
        dir_addr <= ~a;
        acc_wdata <= ~d;
        @(posedge clk);
    endtask : acc
endmodule : dsau_cpu_model

// ### test/tb_dsau_top.sv
// Self-checking bench of the access unit
`timescale 1ns/100ps
module tb_dsau_top;
    logic clk, sys_rst = 1'b1, por_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic acc_req, acc_write, acc_io_op, acc_done, mem_we, io_rdata_vld, cpu_stall, ee_ready_irq, pready, err;
    logic pslverr;
    dsau_pkg::dsau_am_t acc_mode;
    logic [1:0] ptr_sel = 2'h0;
    logic [5:0] io_addr = 6'h00, disp = 6'h00;
    logic [7:0] acc_wdata, io_rdata, rdq[$];
    logic [3:0] mem_sel;
    logic [11:0] paddr = 12'h000;
    logic [15:0] ptr_x = 16'h0000, ptr_y = 16'h0000, ptr_z = 16'h0000, dir_addr, mem_addr, ptr_wb_val, top;
    logic [15:0] bnd[8] = '{16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h00ff, 16'h0100, 16'h02ff, 16'h0300};
    logic [31:0] pwdata = 32'h0, prdata, rnd, rd;
    logic [20:0] expq[$];
    int err_count, n_checks, n;
    dsau_top #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) i_dsau_top (.clk, .sys_rst, .por_rst, .acc_req, .acc_mode,
        .acc_write, .acc_io_op, .io_addr, .dir_addr, .ptr_sel, .ptr_x, .ptr_y, .ptr_z, .disp, .acc_wdata,
        .mem_addr, .mem_sel, .mem_we, .mem_re(), .mem_wdata(), .acc_done, .io_rdata, .io_rdata_vld, .ptr_wb(),
        .ptr_wb_sel(), .ptr_wb_val, .cpu_stall, .ee_ready_irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    dsau_cpu_model i_dsau_cpu_model (.clk, .cpu_stall, .acc_req, .acc_mode, .acc_write, .acc_io_op, .dir_addr,
        .acc_wdata);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [3:0] exp_sel(input logic [15:0] a);
        return a <= 16'h1f ? 4'h1 : a <= 16'h5f ? 4'h2 : a <= 16'hff ? 4'h4 : a <= top ? 4'h8 : 4'h0;
    endfunction : exp_sel
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic go(input dsau_pkg::dsau_am_t m, input logic io, input logic [15:0] ea, input logic [7:0] d);
        expq.push_back({m == dsau_pkg::AM_POSTINC, exp_sel(ea), ea});
        i_dsau_cpu_model.acc(m, m == dsau_pkg::AM_POSTINC, io, ea, d);
    endtask : go
    task automatic st(input logic [15:0] a, input logic [7:0] d);
        expq.push_back({1'b1, exp_sel(a), a});
        i_dsau_cpu_model.acc(dsau_pkg::AM_DIRECT, 1'b1, 1'b0, a, d);
    endtask : st
    // Holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Stall cycles counted since the last request
    always @(posedge clk)
        n <= (acc_req === 1'b1) ? 0 : n + int'(cpu_stall === 1'b1);
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // Results matched against the oldest note
    always @(posedge clk)
    begin
        if (acc_done === 1'b1)
            chk("access", {mem_we, mem_sel, mem_addr}, expq.pop_front());
        if (io_rdata_vld === 1'b1)
            chk("ee data", io_rdata, rdq.pop_front());
    end
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Cuts a hang short
    initial
    begin
        #500000;
        err_count++;
        complete_run;
    end
    initial
    begin
        top = dsau_pkg::SRAM_TOP[0];
        rnd = 32'h9418439a;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        foreach (bnd[i])
            go(dsau_pkg::AM_DIRECT, 1'b0, bnd[i], 8'h00);
        repeat (6)
        begin
            rnd = lfsr(rnd);
            io_addr <= {2'h0, rnd[19:16]};
            go(dsau_pkg::AM_DIRECT, 1'b0, rnd[15:0] & 16'h03ff | 16'h0100, rnd[31:24]);
            go(dsau_pkg::AM_DIRECT, 1'b1, 16'h0020 + rnd[19:16], 8'h00);
        end
        ptr_x <= 16'h0100;
        ptr_y <= 16'h0123;
        ptr_z <= 16'h02ff;
        disp <= 6'h3f;
        ptr_sel <= dsau_pkg::PTR_Y;
        go(dsau_pkg::AM_DISP, 1'b0, 16'h0162, 8'h00);
        go(dsau_pkg::AM_INDIRECT, 1'b0, 16'h0123, 8'h00);
        ptr_sel <= dsau_pkg::PTR_Z;
        go(dsau_pkg::AM_POSTINC, 1'b0, 16'h02ff, 8'h11);
        chk("ptr", ptr_wb_val, 16'h0300);
        ptr_sel <= dsau_pkg::PTR_X;
        go(dsau_pkg::AM_PREDEC, 1'b0, 16'h00ff, 8'h00);
        chk("ptr", ptr_wb_val, 16'h00ff);
        apb(1'b1, dsau_pkg::APB_CFG, 32'h3);
        apb(1'b0, dsau_pkg::APB_CFG, 32'h0);
        chk("cfg", rd, 32'h3);
        top = dsau_pkg::SRAM_TOP[3];
        go(dsau_pkg::AM_DIRECT, 1'b0, 16'h08ff, 8'h00);
        go(dsau_pkg::AM_DIRECT, 1'b0, 16'h0900, 8'h00);
        apb(1'b1, 12'h008, 32'hffffffff);
        chk("slverr", err, 1'b1);
        st(dsau_pkg::EE_DATA_ADR, 8'h5a);
        st(dsau_pkg::EE_ADRL_ADR, 8'h07);
        st(dsau_pkg::EE_ADRH_ADR, 8'h00);
        st(dsau_pkg::EE_CTRL_ADR, 8'h0a);
        repeat (6) @(posedge clk);
        chk("locked", n, 0);
        chk("ready", ee_ready_irq, 1'b1);
        st(dsau_pkg::EE_CTRL_ADR, 8'h0c);
        st(dsau_pkg::EE_CTRL_ADR, 8'h0a);
        repeat (6) @(posedge clk);
        chk("wr stall", n, 2);
        chk("busy", ee_ready_irq, 1'b0);
        repeat (100) @(posedge clk);
        chk("done", ee_ready_irq, 1'b1);
        st(dsau_pkg::EE_DATA_ADR, 8'h00);
        st(dsau_pkg::EE_CTRL_ADR, 8'h09);
        repeat (6) @(posedge clk);
        chk("rd stall", n, 4);
        rdq.push_back(8'h5a);
        go(dsau_pkg::AM_DIRECT, 1'b0, dsau_pkg::EE_DATA_ADR, 8'h00);
        repeat (2) @(posedge clk);
        complete_run;
    end
endmodule : tb_dsau_top
